/* hw/i2c_cmd_regs.svh */
/*
  Constants of the script address and clock-rate commands: supported bus
  rates, direction bit values and clock-phase counts.
  Assumes the core clock rate given by CLK_KHZ.
*/
`ifndef I2C_CMD_REGS_SVH
`define I2C_CMD_REGS_SVH

// core clock, kHz (200 MHz)
`define CLK_KHZ        200000
// supported serial clock rates, kHz, ascending
`define RATE0_KHZ      100
`define RATE1_KHZ      400
`define RATE2_KHZ      1000
`define RATE_RESET_IDX 2'd0
`define RATE_MAX_IDX   2'd2
// direction bit of the address byte
`define DIR_READ       1'b1
`define DIR_WRITE      1'b0
// bit index of the acknowledge slot
`define ACK_BIT        4'd8
// quarter of a serial clock period in core cycles, rounded up
`define QTR_CYC(k)     ((`CLK_KHZ + 4 * (k) - 1) / (4 * (k)))

`endif

/* hw/i2c_cmd_pkg.sv */
/*
  Types of the script command executor.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package i2c_cmd_pkg;
  typedef enum logic [1:0] {
    op_addr_read  = 2'b00,
    op_addr_write = 2'b01,
    op_clk_rate   = 2'b10
  } cmd_op_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_addr = 2'b01
  } exec_state_t;

  typedef logic [1:0]  rate_idx_t;
  typedef logic [15:0] khz_t;
  typedef logic [15:0] cyc_t;
endpackage

`default_nettype wire

/* hw/i2c_bit_if.sv */
/*
  Carrier between the command executor and its byte engine.
  Assumes both ends run on the same core clock.
*/
`default_nettype none

interface i2c_bit_if;
  import i2c_cmd_pkg::*;
  logic       go;
  logic [7:0] tx_byte;
  cyc_t       qtr;
  logic       scl_in;
  logic       sda_in;
  logic       busy;
  logic       done;
  logic       nack;
  logic       scl_low;
  logic       sda_low;

  modport ctl (output go, tx_byte, qtr, scl_in, sda_in,
               input  busy, done, nack, scl_low, sda_low);
  modport eng (input  go, tx_byte, qtr, scl_in, sda_in,
               output busy, done, nack, scl_low, sda_low);
endinterface

`default_nettype wire

/* hw/i2c_byte_engine.sv */
/*
  Shifts one address byte out on the serial bus and samples the ninth-clock
  acknowledge. Assumes synchronised bus levels and a start already on the bus.
*/
`include "i2c_cmd_regs.svh"
`default_nettype none

module i2c_byte_engine (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  i2c_bit_if.eng    bus
);
  import i2c_cmd_pkg::*;

  logic       busy_q;
  logic [3:0] bit_q;
  logic [1:0] ph_q;
  cyc_t       cnt_q;
  logic [7:0] sh_q;
  logic       scl_low_q;
  logic       sda_low_q;
  logic       done_q;
  logic       nack_q;

  wire logic stall = (ph_q == 2'd2) && !bus.scl_in;
  wire logic tick  = !stall && (cnt_q == bus.qtr - 16'd1);
  wire logic last  = (bit_q == `ACK_BIT);

  assign bus.busy    = busy_q;
  assign bus.done    = done_q;
  assign bus.nack    = nack_q;
  assign bus.scl_low = scl_low_q;
  assign bus.sda_low = sda_low_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      bit_q <= 4'h0;
      ph_q <= 2'h0;
      cnt_q <= 16'h0;
      sh_q <= 8'h00;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!busy_q) begin
        if (bus.go) begin
          // no start made
          // start is already on the bus: pull the clock low and hold the data line low
          busy_q <= 1'b1;
          bit_q <= 4'h0;
          ph_q <= 2'h0;
          cnt_q <= 16'h0;
          sh_q <= bus.tx_byte;
          scl_low_q <= 1'b1;
          sda_low_q <= 1'b1;
        end
      end else begin
        if (!stall) begin
          cnt_q <= tick ? 16'h0 : cnt_q + 16'd1;
        end
        if (tick) begin
          ph_q <= ph_q + 2'd1;
          unique case (ph_q)
            2'd0: sda_low_q <= last ? 1'b0 : ~sh_q[7];
            2'd1: scl_low_q <= 1'b0;
            2'd2: if (last) begin
              nack_q <= bus.sda_in;
            end
            2'd3: begin
              scl_low_q <= 1'b1;
              sh_q <= {sh_q[6:0], 1'b0};
              bit_q <= bit_q + 4'd1;
              if (last) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
              end
            end
          endcase
        end
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  data_bit_a: assert property (
    busy_q && !last && ph_q == 2'd1 |-> sda_low_q == ~sh_q[7])
    else $error("data line does not match address bit");
  no_start_a: assert property (
    busy_q && $past(busy_q) && !$past(scl_low_q) |-> $stable(sda_low_q))
    else $error("data line moved while clock released");
  ack_release_a: assert property (
    busy_q && last && ph_q != 2'd0 |-> !sda_low_q)
    else $error("data line not released on ninth clock");
endmodule

`default_nettype wire

/* hw/i2c_script_cmds.sv */
/*
  Script executor for the address-plus-read, address-plus-write and
  clock-rate commands on one of several open-drain serial ports.
  Assumes the script source presents one command at a time and that
  start, stop and data commands are handled elsewhere.
*/
`include "i2c_cmd_regs.svh"
`default_nettype none

// Contract
// - address-plus-read sends the 7-bit address then direction bit one
// - address-plus-write sends the 7-bit address then direction bit zero
// - address byte: address in bits seven to one, direction in bit zero
// - addressing commands never make a start; one is assumed present
// - release data line on ninth clock and sample the acknowledge
// - on not-acknowledge stop the script and report an error
// - serial clock runs only at one of the fixed supported rates
// - unsupported rate falls to nearest lower rate with a warning
// - rate below all supported rates is rejected with an error
// - commands act on the port chosen at launch
module i2c_script_cmds #(
  parameter int NPORTS = 1,
  parameter int PW     = (NPORTS > 1) ? $clog2(NPORTS) : 1
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                run_start,
  input  wire logic [PW-1:0]       run_port,
  input  wire logic                cmd_valid,
  output var  logic                cmd_ready,
  input  wire i2c_cmd_pkg::cmd_op_t cmd_op,
  input  wire logic [6:0]          cmd_addr,
  input  wire i2c_cmd_pkg::khz_t   cmd_rate_khz,
  output var  logic                resp_valid,
  output var  logic                resp_err,
  output var  logic                resp_warn,
  output var  logic                resp_nack,
  output var  logic                script_abort,
  input  wire logic [NPORTS-1:0]   scl_i,
  output var  logic [NPORTS-1:0]   scl_o,
  output var  logic [NPORTS-1:0]   scl_oe,
  input  wire logic [NPORTS-1:0]   sda_i,
  output var  logic [NPORTS-1:0]   sda_o,
  output var  logic [NPORTS-1:0]   sda_oe
);
  import i2c_cmd_pkg::*;

  // highest supported rate not above the request: {ok, exact, idx}
  function automatic logic [3:0] pick_rate(input khz_t req);
    logic [3:0] r;
    r = 4'h0;
    if (req >= 16'(`RATE2_KHZ)) begin
      r = {1'b1, req == 16'(`RATE2_KHZ), 2'd2};
    end else if (req >= 16'(`RATE1_KHZ)) begin
      r = {1'b1, req == 16'(`RATE1_KHZ), 2'd1};
    end else if (req >= 16'(`RATE0_KHZ)) begin
      r = {1'b1, req == 16'(`RATE0_KHZ), 2'd0};
    end
    return r;
  endfunction

  function automatic cyc_t qtr_of(input rate_idx_t idx);
    cyc_t c;
    c = 16'(`QTR_CYC(`RATE0_KHZ));
    if (idx == 2'd1) begin
      c = 16'(`QTR_CYC(`RATE1_KHZ));
    end else if (idx == 2'd2) begin
      c = 16'(`QTR_CYC(`RATE2_KHZ));
    end
    return c;
  endfunction

  i2c_bit_if bit_bus ();

  exec_state_t       state_q;
  logic              cmd_ready_q;
  logic              resp_valid_q;
  logic              resp_err_q;
  logic              resp_warn_q;
  logic              resp_nack_q;
  logic              aborted_q;
  logic [PW-1:0]     port_q;
  logic              go_q;
  logic [7:0]        tx_q;
  rate_idx_t         rate_idx_q [NPORTS];
  logic [NPORTS-1:0] scl_m_q;
  logic [NPORTS-1:0] scl_s_q;
  logic [NPORTS-1:0] sda_m_q;
  logic [NPORTS-1:0] sda_s_q;
  logic [NPORTS-1:0] scl_oe_q;
  logic [NPORTS-1:0] sda_oe_q;

  wire logic       launch    = run_start && (state_q == st_idle);
  wire logic       take      = cmd_valid && cmd_ready_q && !run_start;
  wire logic       is_addr   = (cmd_op == op_addr_read) ||
                               (cmd_op == op_addr_write);
  wire logic       is_rate   = (cmd_op == op_clk_rate);
  wire logic [3:0] pick      = pick_rate(cmd_rate_khz);
  wire logic       rate_ok   = pick[3];
  wire logic       rate_ex   = pick[2];
  wire logic       start_bus = take && is_addr && !aborted_q;
  wire logic       dir_bit   = (cmd_op == op_addr_read) ? `DIR_READ
                                                        : `DIR_WRITE;
  wire logic       nack_end  = (state_q == st_addr) && bit_bus.done &&
                               bit_bus.nack;
  wire logic       addr_end  = (state_q == st_addr) && bit_bus.done;

  assign bit_bus.go      = go_q;
  assign bit_bus.tx_byte = tx_q;
  // only table rates reach the divider
  assign bit_bus.qtr     = qtr_of(rate_idx_q[port_q]);
  assign bit_bus.scl_in  = scl_s_q[port_q];
  assign bit_bus.sda_in  = sda_s_q[port_q];

  i2c_byte_engine u_engine (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .bus     (bit_bus.eng)
  );

  genvar p;
  generate
    for (p = 0; p < NPORTS; p++) begin : g_port
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          scl_m_q[p] <= 1'b1;
          scl_s_q[p] <= 1'b1;
          sda_m_q[p] <= 1'b1;
          sda_s_q[p] <= 1'b1;
          scl_oe_q[p] <= 1'b0;
          sda_oe_q[p] <= 1'b0;
          rate_idx_q[p] <= `RATE_RESET_IDX;
        end else begin
          scl_m_q[p] <= scl_i[p];
          scl_s_q[p] <= scl_m_q[p];
          sda_m_q[p] <= sda_i[p];
          sda_s_q[p] <= sda_m_q[p];
          // only the launched port follows the engine; the other ports keep their last drive
          if (port_q == PW'(p)) begin
            scl_oe_q[p] <= bit_bus.scl_low;
            sda_oe_q[p] <= bit_bus.sda_low;
          end
          // round down to a supported rate
          if (take && is_rate && !aborted_q && rate_ok &&
              port_q == PW'(p)) begin
            rate_idx_q[p] <= pick[1:0];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= st_idle;
      cmd_ready_q <= 1'b0;
      resp_valid_q <= 1'b0;
      resp_err_q <= 1'b0;
      resp_warn_q <= 1'b0;
      resp_nack_q <= 1'b0;
      aborted_q <= 1'b0;
      port_q <= '0;
      go_q <= 1'b0;
      tx_q <= 8'h00;
    end else begin
      go_q <= 1'b0;
      resp_valid_q <= 1'b0;
      if (launch) begin
        port_q <= run_port;
      end
      // abort set wins over relaunch clear
      aborted_q <= nack_end || (aborted_q && !launch);
      unique case (state_q)
        st_idle: begin
          cmd_ready_q <= !take;
          if (take) begin
            resp_nack_q <= 1'b0;
            resp_warn_q <= 1'b0;
            resp_err_q <= 1'b0;
            if (start_bus) begin
              tx_q <= {cmd_addr, dir_bit};
              go_q <= 1'b1;
              state_q <= st_addr;
            end else begin
              resp_valid_q <= 1'b1;
              resp_err_q <= aborted_q || !is_rate || !rate_ok;
              resp_warn_q <= !aborted_q && is_rate && rate_ok && !rate_ex;
            end
          end
        end
        st_addr: begin
          // wait for the byte to finish
          if (addr_end) begin
            state_q <= st_idle;
            cmd_ready_q <= 1'b1;
            resp_valid_q <= 1'b1;
            resp_err_q <= bit_bus.nack;
            resp_nack_q <= bit_bus.nack;
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  assign cmd_ready    = cmd_ready_q;
  assign resp_valid   = resp_valid_q;
  assign resp_err     = resp_err_q;
  assign resp_warn    = resp_warn_q;
  assign resp_nack    = resp_nack_q;
  assign script_abort = aborted_q;
  assign scl_oe       = scl_oe_q;
  assign sda_oe       = sda_oe_q;
  assign scl_o        = '0;
  assign sda_o        = '0;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  read_byte_a: assert property (
    take && !aborted_q && cmd_op == op_addr_read |=>
      go_q && tx_q == {$past(cmd_addr), 1'b1})
    else $error("read address byte wrong");
  write_byte_a: assert property (
    take && !aborted_q && cmd_op == op_addr_write |=>
      go_q && tx_q == {$past(cmd_addr), 1'b0})
    else $error("write address byte wrong");
  nack_abort_a: assert property (
    nack_end |=> script_abort && resp_valid && resp_err && resp_nack)
    else $error("not-acknowledge did not abort");
  skip_after_a: assert property (
    take && aborted_q |=> !go_q && resp_valid && resp_err ##1 !go_q)
    else $error("command ran after abort");
  rate_set_a: assert property (
    take && is_rate && !aborted_q && rate_ok |=>
      rate_idx_q[port_q] == $past(pick[1:0]))
    else $error("rate not stored for run port");
  rate_legal_a: assert property (
    rate_idx_q[port_q] <= `RATE_MAX_IDX)
    else $error("rate index outside table");
  rate_warn_a: assert property (
    take && is_rate && !aborted_q && rate_ok && !rate_ex |=>
      resp_valid && resp_warn && !resp_err)
    else $error("rounded rate without warning");
  rate_low_a: assert property (
    take && is_rate && !rate_ok |=>
      resp_valid && resp_err && !resp_warn && $stable(rate_idx_q[port_q]))
    else $error("too low rate not rejected");
  port_launch_a: assert property (
    launch |=> port_q == $past(run_port))
    else $error("port not taken at launch");
  in_order_a: assert property (
    go_q |-> !cmd_ready_q ##1 (!cmd_ready_q && !resp_valid)[*2])
    else $error("next command accepted during bus action");
endmodule

`default_nettype wire

/* dv/i2c_target_model.sv */
/*
  Behavioural target on one open-drain serial port: shifts in the address
  byte, acknowledges its own address, can stretch the clock low.
  Assumes wired-and lines with pull-ups, sampled on the core clock.
*/
`default_nettype none

module i2c_target_model #(
  parameter logic [6:0] ADDR = 7'h52
) (
  input  wire logic        ref_clk,
  input  wire logic        scl,
  input  wire logic        sda,
  input  wire logic [15:0] stretch,
  output var  logic        scl_pull,
  output var  logic        sda_pull,
  output var  logic [7:0]  last_byte,
  output var  logic [7:0]  bytes,
  output var  logic [7:0]  edges_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        scl_p;
  logic        sda_p;
  logic [3:0]  bit_n;
  logic [7:0]  sh;
  logic [15:0] hold;

  initial begin
    {scl_pull, sda_pull, last_byte, bytes, edges_hi} = '0;
    {bit_n, sh, hold} = '0;
    scl_p = 1'b1;
    sda_p = 1'b1;
  end

  always @(posedge ref_clk) begin
    scl_p <= scl;
    sda_p <= sda;
    // data moving while clock high is a start or a stop
    if (scl && scl_p && sda != sda_p) edges_hi <= edges_hi + 8'h01;
    if (scl && !scl_p) begin
      if (bit_n == 4'h8) begin
        bit_n <= 4'h0;
      end else begin
        sh    <= {sh[6:0], sda};
        bit_n <= bit_n + 4'h1;
        if (bit_n == 4'h7) begin
          last_byte <= {sh[6:0], sda};
          bytes     <= bytes + 8'h01;
        end
      end
    end
    if (!scl && scl_p) begin
      // pull data low through the ninth clock for our own address only
      sda_pull <= (bit_n == 4'h8) && (sh[7:1] == ADDR);
      hold     <= stretch;
      scl_pull <= (stretch != 16'h0000);
    end else if (hold > 16'h0001) begin
      hold <= hold - 16'h0001;
    end else begin
      scl_pull <= 1'b0;
    end
  end
endmodule

`default_nettype wire

/* dv/i2c_script_addr_clock_cmds_test.sv */
/*
  Self-checking bench of the script command executor on two ports, each
  with its own target model. Assumes the executor's hand-over timing.
*/
`include "i2c_cmd_regs.svh"
`default_nettype none

`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end

module i2c_script_addr_clock_cmds_test;
  timeunit 1ns;
  timeprecision 1ps;
  import i2c_cmd_pkg::*;
  localparam int Q1 = `CLK_KHZ / (4 * `RATE1_KHZ);
  localparam int Q2 = `CLK_KHZ / (4 * `RATE2_KHZ);
  logic        ref_clk, rst_n, run_start, run_port, cmd_valid;
  cmd_op_t     cmd_op;
  logic [6:0]  cmd_addr;
  khz_t        cmd_rate_khz;
  logic        cmd_ready, resp_valid, resp_err, resp_warn, resp_nack;
  logic        script_abort, mon, scl_prev;
  logic [1:0]  scl_o, scl_oe, sda_o, sda_oe, scl_w, sda_w;
  logic [1:0]  scl_pull, sda_pull;
  logic [7:0]  last_byte [2];
  logic [7:0]  bytes [2];
  logic [7:0]  edges [2];
  logic [7:0]  b0;
  logic [15:0] stretch;
  int          bad_count, checked, cyc, per, last_rise;

  assign scl_w = ~scl_oe & ~scl_pull;
  assign sda_w = ~sda_oe & ~sda_pull;

  i2c_script_cmds #(.NPORTS(2)) DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .run_start(run_start),
    .run_port(run_port), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_rate_khz(cmd_rate_khz),
    .resp_valid(resp_valid), .resp_err(resp_err), .resp_warn(resp_warn),
    .resp_nack(resp_nack), .script_abort(script_abort), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe)
  );

  for (genvar g = 0; g < 2; g++) begin : tgt
    i2c_target_model #(.ADDR(g == 0 ? 7'h52 : 7'h51)) model (
      .ref_clk(ref_clk), .scl(scl_w[g]), .sda(sda_w[g]),
      .stretch(stretch), .scl_pull(scl_pull[g]), .sda_pull(sda_pull[g]),
      .last_byte(last_byte[g]), .bytes(bytes[g]), .edges_hi(edges[g])
    );
  end

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // clock-high to clock-high spacing on the watched port, and the timeout
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    scl_prev <= scl_w[mon];
    if (scl_w[mon] && !scl_prev) begin
      per       <= cyc - last_rise;
      last_rise <= cyc;
    end
    if (cyc == 60000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cmd(input cmd_op_t op, input logic [6:0] a, input khz_t r);
    int n;
    n = 0;
    // let an edge pass since the previous request dropped valid
    @(negedge ref_clk);
    cmd_op = op;
    cmd_addr = a;
    cmd_rate_khz = r;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    `CHK("ready low after take", 1'b0, cmd_ready)
    while (resp_valid !== 1'b1 && n < 40000) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK("answer given", 1'b1, resp_valid)
  endtask

  task automatic launch(input logic p);
    run_port = p;
    run_start = 1'b1;
    @(negedge ref_clk);
    run_start = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic t_rate;
    khz_t req [8];
    logic e_err [8];
    logic e_warn [8];
    req = '{16'd50, 16'd99, 16'd100, 16'd250, 16'd400, 16'd999, 16'd1000,
            16'hffff};
    e_err = '{1, 1, 0, 0, 0, 0, 0, 0};
    e_warn = '{0, 0, 0, 1, 0, 1, 0, 1};
    for (int i = 0; i < 8; i++) begin
      cmd(op_clk_rate, 7'h00, req[i]);
      `CHK("rate error", e_err[i], resp_err)
      `CHK("rate warning", e_warn[i], resp_warn)
    end
    cmd(cmd_op_t'(2'b11), 7'h00, 16'd100);
    `CHK("illegal op error", 1'b1, resp_err)
  endtask

  task automatic t_read;
    launch(1'b0);
    cmd(op_clk_rate, 7'h00, 16'd450);
    `CHK("rounded rate warning", 1'b1, resp_warn)
    mon = 1'b0;
    cmd(op_addr_read, 7'(8'ha4 >> 1), 16'd0);
    `CHK("read byte", {7'h52, `DIR_READ}, last_byte[0])
    `CHK("read acked", 1'b0, resp_nack)
    `CHK("read no error", 1'b0, resp_err)
    `CHK("period at 400k", 1'b1, per >= 4 * Q1 && per <= 4 * Q1 + 4)
  endtask

  task automatic t_write;
    launch(1'b1);
    cmd(op_clk_rate, 7'h00, 16'd1000);
    `CHK("exact rate no warning", 1'b0, resp_warn)
    b0 = bytes[0];
    mon = 1'b1;
    stretch = 16'd300;
    cmd(op_addr_write, 7'h51, 16'd0);
    `CHK("write byte", {7'h51, `DIR_WRITE}, last_byte[1])
    `CHK("stretched write acked", 1'b0, resp_nack)
    stretch = 16'd0;
    cmd(op_addr_write, 7'h51, 16'd0);
    `CHK("period at 1000k", 1'b1, per >= 4 * Q2 && per <= 4 * Q2 + 4)
    `CHK("other port quiet", b0, bytes[0])
  endtask

  task automatic t_nack;
    launch(1'b0);
    cmd(op_addr_read, 7'h11, 16'd0);
    `CHK("nack flag", 1'b1, resp_nack)
    `CHK("nack error", 1'b1, resp_err)
    `CHK("script stopped", 1'b1, script_abort)
    b0 = bytes[0];
    cmd(op_addr_write, 7'h52, 16'd0);
    `CHK("stopped command error", 1'b1, resp_err)
    `CHK("no bus action", b0, bytes[0])
    launch(1'b0);
    `CHK("relaunch clears stop", 1'b0, script_abort)
    mon = 1'b0;
    cmd(op_addr_read, 7'h52, 16'd0);
    `CHK("relaunch acked", 1'b0, resp_nack)
    `CHK("port 0 keeps 400k", 1'b1, per >= 4 * Q1 && per <= 4 * Q1 + 4)
    `CHK("clock drive level", 2'b00, scl_o)
    `CHK("data drive level", 2'b00, sda_o)
    `CHK("no start port 0", 8'h00, edges[0])
    `CHK("no start port 1", 8'h00, edges[1])
  endtask

  initial begin
    {rst_n, run_start, run_port, cmd_valid, mon, scl_prev} = '0;
    cmd_op = op_addr_read;
    cmd_addr = 7'h00;
    cmd_rate_khz = 16'd0;
    stretch = 16'd0;
    {bad_count, checked, cyc, per, last_rise} = '0;
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    t_rate();
    t_read();
    t_write();
    t_nack();
    complete_run();
  end
endmodule

`default_nettype wire
